// File: hdl/ccs_pkg.sv
// package: offsets, field positions, reset values and encodings of the codec control/status registers
package ccs_pkg;

  // register access port widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] MODE_STATUS_ADDR = 6'h06;
  localparam logic [ADDR_W-1:0] COEF_N0_ADDR     = 6'h07;

  // field positions in codec_mode_status
  localparam int VOL_LINK_MSB = 15;
  localparam int VOL_LINK_LSB = 14;
  localparam int REF_RATE_BIT = 13;
  localparam int XFER_BIT     = 12;
  localparam int MS_BIT       = 11;
  localparam int RSVD_RO_MSB  = 10;
  localparam int RSVD_RO_LSB  = 9;
  localparam int OVF_MSB      = 8;  // adc overflow
  localparam int OVF_LSB      = 6;  // dac right overflow
  localparam int RSVD_RW_MSB  = 5;
  localparam int RSVD_RW_LSB  = 4;
  localparam int CLIP_BIT     = 3;
  localparam int REV_MSB      = 2;
  localparam int REV_LSB      = 0;

  // overflow flag indices inside the three-bit flag vector
  localparam int NUM_OVF      = 3;
  localparam int OVF_ADC      = 2;
  localparam int OVF_DAC_L    = 1;
  localparam int OVF_DAC_R    = 0;

  // dac volume link encodings
  typedef enum logic [1:0] {
    VL_INDEP       = 2'h0,
    VL_RIGHT_TO_LR = 2'h1,
    VL_LEFT_TO_LR  = 2'h2,
    VL_INDEP_ALT   = 2'h3
  } ccs_vol_link_t;

  // reference rate, transfer mode, role encodings
  localparam logic REF_48K     = 1'b0;
  localparam logic REF_44K1    = 1'b1;
  localparam logic XFER_CONT   = 1'b0;
  localparam logic XFER_256    = 1'b1;
  localparam logic ROLE_SLAVE  = 1'b0;
  localparam logic ROLE_MASTER = 1'b1;

  // reset values
  localparam logic [1:0]        VOL_LINK_RST = 2'h0;
  localparam logic              REF_RATE_RST = 1'b0;
  localparam logic              XFER_RST     = 1'b0;
  localparam logic              MS_RST       = 1'b0;
  localparam logic [1:0]        RSVD_RW_RST  = 2'h0;
  localparam logic              CLIP_RST     = 1'b0;
  localparam logic              OVF_RST      = 1'b0;
  localparam logic [DATA_W-1:0] COEF_N0_RST  = 16'h6be3;  // 27619 decimal

endpackage

// File: hdl/ccs_regs.sv
// codec control/status register and left bass-boost coefficient n0
`timescale 1ns/10ps
module ccs_regs #(
  parameter int                  VOL_W        = 7,
  parameter int                  DEEMPH_W     = 16,
  parameter logic [DEEMPH_W-1:0] DEEMPH_48K   = 16'h0100,
  parameter logic [DEEMPH_W-1:0] DEEMPH_44K1  = 16'h0200,
  parameter logic [7:0]          AGC_TC_48K   = 8'h30,
  parameter logic [7:0]          AGC_TC_44K1  = 8'h2c,
  parameter logic [7:0]          TSC_DIV_48K  = 8'h08,
  parameter logic [7:0]          TSC_DIV_44K1 = 8'h07,
  parameter logic [2:0]          REVISION     = 3'h1  // arbitrary value
) (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  // register access from the serial control port
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic [ccs_pkg::ADDR_W-1:0]    i_reg_addr,
  input  wire logic [ccs_pkg::DATA_W-1:0]    i_reg_wdata,
  output logic [ccs_pkg::DATA_W-1:0]         o_reg_rdata,
  output logic                               o_reg_rvalid,
  // datapath events and context
  input  wire logic [ccs_pkg::NUM_OVF-1:0]   i_ovf_event,
  input  wire logic [VOL_W-1:0]              i_dac_left_vol,
  input  wire logic [VOL_W-1:0]              i_dac_right_vol,
  input  wire logic                          i_agc_selected,
  input  wire logic                          i_effects_filter_enable,
  // applied controls
  output logic [VOL_W-1:0]                   o_dac_left_vol_eff,
  output logic [VOL_W-1:0]                   o_dac_right_vol_eff,
  output logic [DEEMPH_W-1:0]                o_deemph_coef,
  output logic [7:0]                         o_agc_time_const,
  output logic [7:0]                         o_tsc_clk_div,
  output logic                               o_transfer_mode_select,
  output logic                               o_master_slave_select,
  output logic                               o_mic_agc_clip_step_active,
  output logic                               o_effects_active,
  output logic [ccs_pkg::DATA_W-1:0]         o_left_bass_coef_n0
);
  import ccs_pkg::*;

  // stored fields
  ccs_vol_link_t        dac_volume_link;
  logic                 reference_rate_select;
  logic                 transfer_mode_select;
  logic                 master_slave_select;
  logic [1:0]           rsvd_rw;
  logic                 mic_agc_clip_step;
  logic [DATA_W-1:0]    left_bass_coef_n0;
  logic [NUM_OVF-1:0]   ovf_flags;

  ccs_vol_link_t        next_dac_volume_link;
  logic                 next_reference_rate_select;
  logic                 next_transfer_mode_select;
  logic                 next_master_slave_select;
  logic [1:0]           next_rsvd_rw;
  logic                 next_mic_agc_clip_step;
  logic [DATA_W-1:0]    next_left_bass_coef_n0;
  logic [DATA_W-1:0]    next_reg_rdata;
  logic                 next_reg_rvalid;
  logic                 status_read;
  logic                 wr_mode;
  logic                 wr_coef;

  // decode; unmapped addresses ignore writes and read back zero
  assign wr_mode     = i_reg_wr && (i_reg_addr == MODE_STATUS_ADDR);
  assign wr_coef     = i_reg_wr && (i_reg_addr == COEF_N0_ADDR);
  assign status_read = i_reg_rd && (i_reg_addr == MODE_STATUS_ADDR);

  // overflow flags, cleared by the same read that returns them
  genvar g;
  generate
    for (g = 0; g < NUM_OVF; g++) begin : g_ovf
      ccs_sticky_flag u_flag (
        .i_clk   (i_clk),
        .i_sys_rst(i_sys_rst),
        .i_set   (i_ovf_event[g]),
        .i_clear (status_read),
        .o_flag  (ovf_flags[g])
      );
    end
  endgenerate

  // next values of writable fields
  always_comb begin
    next_dac_volume_link       = dac_volume_link;
    next_reference_rate_select = reference_rate_select;
    next_transfer_mode_select  = transfer_mode_select;
    next_master_slave_select   = master_slave_select;
    next_rsvd_rw               = rsvd_rw;
    next_mic_agc_clip_step     = mic_agc_clip_step;
    next_left_bass_coef_n0     = left_bass_coef_n0;
    if (wr_mode) begin
      next_dac_volume_link       = ccs_vol_link_t'(i_reg_wdata[VOL_LINK_MSB:VOL_LINK_LSB]);
      next_reference_rate_select = i_reg_wdata[REF_RATE_BIT];
      next_transfer_mode_select  = i_reg_wdata[XFER_BIT];
      next_master_slave_select   = i_reg_wdata[MS_BIT];
      next_rsvd_rw               = i_reg_wdata[RSVD_RW_MSB:RSVD_RW_LSB];
      next_mic_agc_clip_step     = i_reg_wdata[CLIP_BIT];
    end
    if (wr_coef) begin
      next_left_bass_coef_n0 = i_reg_wdata;
    end
  end

  // read data: captured in the read cycle, so a clearing read still reports the flags
  always_comb begin
    next_reg_rdata  = '0;
    next_reg_rvalid = i_reg_rd;
    case (i_reg_addr)
      MODE_STATUS_ADDR: begin
        next_reg_rdata[VOL_LINK_MSB:VOL_LINK_LSB] = dac_volume_link;
        next_reg_rdata[REF_RATE_BIT]              = reference_rate_select;
        next_reg_rdata[XFER_BIT]                  = transfer_mode_select;
        next_reg_rdata[MS_BIT]                    = master_slave_select;
        next_reg_rdata[RSVD_RO_MSB:RSVD_RO_LSB]   = 2'h0;
        next_reg_rdata[OVF_MSB:OVF_LSB]           = ovf_flags;
        next_reg_rdata[RSVD_RW_MSB:RSVD_RW_LSB]   = rsvd_rw;
        next_reg_rdata[CLIP_BIT]                  = mic_agc_clip_step;
        next_reg_rdata[REV_MSB:REV_LSB]           = REVISION;
      end
      COEF_N0_ADDR: begin
        next_reg_rdata = left_bass_coef_n0;
      end
      default: next_reg_rdata = '0;
    endcase
    if (!i_reg_rd) begin
      next_reg_rdata = o_reg_rdata;  // hold last answer between reads
    end
  end

  // register file
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dac_volume_link       <= ccs_vol_link_t'(VOL_LINK_RST);
      reference_rate_select <= REF_RATE_RST;
      transfer_mode_select  <= XFER_RST;
      master_slave_select   <= MS_RST;
      rsvd_rw               <= RSVD_RW_RST;
      mic_agc_clip_step     <= CLIP_RST;
      left_bass_coef_n0     <= COEF_N0_RST;
      o_reg_rdata           <= '0;
      o_reg_rvalid          <= 1'b0;
    end else begin
      dac_volume_link       <= next_dac_volume_link;
      reference_rate_select <= next_reference_rate_select;
      transfer_mode_select  <= next_transfer_mode_select;
      master_slave_select   <= next_master_slave_select;
      rsvd_rw               <= next_rsvd_rw;
      mic_agc_clip_step     <= next_mic_agc_clip_step;
      left_bass_coef_n0     <= next_left_bass_coef_n0;
      o_reg_rdata           <= next_reg_rdata;
      o_reg_rvalid          <= next_reg_rvalid;
    end
  end

  // applied controls, one cycle behind the stored fields
  logic [VOL_W-1:0]    next_left_eff;
  logic [VOL_W-1:0]    next_right_eff;
  logic [DEEMPH_W-1:0] next_deemph;
  logic [7:0]          next_agc_tc;
  logic [7:0]          next_tsc_div;
  logic                next_clip_active;
  logic [DATA_W-1:0]   next_coef_out;

  always_comb begin
    next_left_eff  = i_dac_left_vol;
    next_right_eff = i_dac_right_vol;
    case (dac_volume_link)
      VL_RIGHT_TO_LR: next_left_eff  = i_dac_right_vol;
      VL_LEFT_TO_LR:  next_right_eff = i_dac_left_vol;
      default:        next_left_eff  = i_dac_left_vol;   // 00 and 11 keep channels apart
    endcase
    // one select steers all three rate-dependent settings
    next_deemph  = (reference_rate_select == REF_44K1) ? DEEMPH_44K1  : DEEMPH_48K;
    next_agc_tc  = (reference_rate_select == REF_44K1) ? AGC_TC_44K1  : AGC_TC_48K;
    next_tsc_div = (reference_rate_select == REF_44K1) ? TSC_DIV_44K1 : TSC_DIV_48K;
    next_clip_active = mic_agc_clip_step & i_agc_selected;
    // a disabled filter sees zero coefficients rather than a stale set
    next_coef_out    = i_effects_filter_enable ? left_bass_coef_n0 : '0;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_dac_left_vol_eff         <= '0;
      o_dac_right_vol_eff        <= '0;
      o_deemph_coef              <= DEEMPH_48K;
      o_agc_time_const           <= AGC_TC_48K;
      o_tsc_clk_div              <= TSC_DIV_48K;
      o_transfer_mode_select     <= XFER_CONT;
      o_master_slave_select      <= ROLE_SLAVE;
      o_mic_agc_clip_step_active <= 1'b0;
      o_effects_active           <= 1'b0;
      o_left_bass_coef_n0        <= '0;
    end else begin
      o_dac_left_vol_eff         <= next_left_eff;
      o_dac_right_vol_eff        <= next_right_eff;
      o_deemph_coef              <= next_deemph;
      o_agc_time_const           <= next_agc_tc;
      o_tsc_clk_div              <= next_tsc_div;
      o_transfer_mode_select     <= transfer_mode_select;
      o_master_slave_select      <= master_slave_select;
      o_mic_agc_clip_step_active <= next_clip_active;
      o_effects_active           <= i_effects_filter_enable;
      o_left_bass_coef_n0        <= next_coef_out;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_vol_indep;
    (dac_volume_link == VL_INDEP || dac_volume_link == VL_INDEP_ALT)
      |=> (o_dac_left_vol_eff == $past(i_dac_left_vol)) && (o_dac_right_vol_eff == $past(i_dac_right_vol));
  endproperty
  a_vol_indep: assert property (p_vol_indep) else $error("independent volumes not kept");

  property p_vol_right_both;
    dac_volume_link == VL_RIGHT_TO_LR |=> o_dac_left_vol_eff == $past(i_dac_right_vol);
  endproperty
  a_vol_right_both: assert property (p_vol_right_both) else $error("right volume not copied left");

  property p_vol_left_both;
    dac_volume_link == VL_LEFT_TO_LR |=> o_dac_right_vol_eff == $past(i_dac_left_vol);
  endproperty
  a_vol_left_both: assert property (p_vol_left_both) else $error("left volume not copied right");

  property p_rate_44k1;
    reference_rate_select == REF_44K1
      |=> (o_deemph_coef == DEEMPH_44K1) && (o_agc_time_const == AGC_TC_44K1) && (o_tsc_clk_div == TSC_DIV_44K1);
  endproperty
  a_rate_44k1: assert property (p_rate_44k1) else $error("44.1 kHz settings not applied");

  property p_rate_write;
    wr_mode ##1 1'b1 |=> o_tsc_clk_div == ($past(i_reg_wdata[REF_RATE_BIT], 2) ? TSC_DIV_44K1 : TSC_DIV_48K);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate write not reflected");

  property p_role_write;
    wr_mode |=> ##1 (o_master_slave_select == $past(i_reg_wdata[MS_BIT], 2))
                 && (o_transfer_mode_select == $past(i_reg_wdata[XFER_BIT], 2));
  endproperty
  a_role_write: assert property (p_role_write) else $error("mode or role not applied");

  property p_ovf_set;
    i_ovf_event[OVF_ADC] |=> ovf_flags[OVF_ADC];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("adc overflow lost");

  property p_ovf_clear;
    status_read && !i_ovf_event[OVF_DAC_L] && !i_ovf_event[OVF_DAC_R]
      |=> !ovf_flags[OVF_DAC_L] && !ovf_flags[OVF_DAC_R] && o_reg_rvalid;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("dac overflow not cleared by read");

  property p_status_fixed;
    status_read |=> o_reg_rdata[REV_MSB:REV_LSB] == REVISION && o_reg_rdata[RSVD_RO_MSB:RSVD_RO_LSB] == 2'h0
                    && o_reg_rdata[OVF_LSB] == $past(ovf_flags[OVF_DAC_R]);
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status readback wrong");

  property p_clip_gate;
    !i_agc_selected |=> !o_mic_agc_clip_step_active;
  endproperty
  a_clip_gate: assert property (p_clip_gate) else $error("clip stepping without agc");

  property p_coef_gate;
    !i_effects_filter_enable |=> (o_left_bass_coef_n0 == '0) && !o_effects_active;
  endproperty
  a_coef_gate: assert property (p_coef_gate) else $error("coefficients applied while disabled");

  property p_coef_rw;
    wr_coef ##1 (i_reg_rd && i_reg_addr == COEF_N0_ADDR && !wr_coef) |=> o_reg_rdata == $past(i_reg_wdata, 2);
  endproperty
  a_coef_rw: assert property (p_coef_rw) else $error("coefficient readback wrong");

  c_clear_read:  cover property (status_read && |ovf_flags);
  c_set_on_read: cover property (status_read && i_ovf_event[OVF_ADC]);
  c_link_right:  cover property (dac_volume_link == VL_RIGHT_TO_LR && i_dac_left_vol != i_dac_right_vol);
  c_effects_on:  cover property (wr_coef ##1 i_effects_filter_enable);

endmodule

// File: hdl/ccs_sticky_flag.sv
// sticky event flag, cleared by a register read, set winning over clear
`timescale 1ns/10ps
module ccs_sticky_flag (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // event and clear
  input  wire logic i_set,
  input  wire logic i_clear,
  // flag
  output logic      o_flag
);
  import ccs_pkg::*;

  logic next_flag;

  // an event in the clearing cycle must survive the read
  always_comb begin
    next_flag = i_set | (o_flag & ~i_clear);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_flag <= OVF_RST;
    end else begin
      o_flag <= next_flag;
    end
  end

endmodule

// File: verification/ccs_regs_tb.sv
// self-checking testbench for the codec control/status registers
`timescale 1ns/10ps
module ccs_regs_tb;
  import ccs_pkg::*;

  // rate-dependent settings and revision handed to the design
  localparam logic [15:0] D48 = 16'h0100;
  localparam logic [15:0] D44 = 16'h0200;
  localparam logic [7:0]  A48 = 8'h30;
  localparam logic [7:0]  A44 = 8'h2c;
  localparam logic [7:0]  T48 = 8'h08;
  localparam logic [7:0]  T44 = 8'h07;
  localparam logic [2:0]  REV = 3'h1;  // arbitrary value

  // one table row: write word and context, then expected results
  typedef struct packed {
    logic [15:0] wd;
    logic [6:0]  lv, rv;
    logic        agc, fe;
    logic [15:0] rd;
    logic [6:0]  el, er;
    logic        rate, xfer, ms, clip, fx;
    logic [15:0] coef;
  } ccs_row_t;

  logic              i_clk, i_sys_rst, i_reg_wr, i_reg_rd, o_reg_rvalid;
  logic [ADDR_W-1:0] i_reg_addr;
  logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata, o_deemph_coef, o_left_bass_coef_n0;
  logic [2:0]        i_ovf_event;
  logic [6:0]        i_dac_left_vol, i_dac_right_vol, o_dac_left_vol_eff, o_dac_right_vol_eff;
  logic              i_agc_selected, i_effects_filter_enable;
  logic [7:0]        o_agc_time_const, o_tsc_clk_div;
  logic              o_transfer_mode_select, o_master_slave_select, o_mic_agc_clip_step_active, o_effects_active;
  int                failures = 0;
  int                compares = 0;

  ccs_row_t rows [12] = '{
    '{16'h0000, 7'h0a, 7'h14, 1'b0, 1'b0, 16'h0001, 7'h0a, 7'h14, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'h4000, 7'h0a, 7'h14, 1'b0, 1'b0, 16'h4001, 7'h14, 7'h14, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'h8000, 7'h0a, 7'h14, 1'b0, 1'b0, 16'h8001, 7'h0a, 7'h0a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'hc000, 7'h0a, 7'h14, 1'b0, 1'b0, 16'hc001, 7'h0a, 7'h14, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'h2000, 7'h0a, 7'h14, 1'b0, 1'b0, 16'h2001, 7'h0a, 7'h14, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'h1000, 7'h0a, 7'h14, 1'b0, 1'b0, 16'h1001, 7'h0a, 7'h14, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'h0800, 7'h0a, 7'h14, 1'b0, 1'b0, 16'h0801, 7'h0a, 7'h14, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000},
    '{16'h0008, 7'h0a, 7'h14, 1'b0, 1'b0, 16'h0009, 7'h0a, 7'h14, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'h0008, 7'h0a, 7'h14, 1'b1, 1'b0, 16'h0009, 7'h0a, 7'h14, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000},
    '{16'h0000, 7'h0a, 7'h14, 1'b1, 1'b0, 16'h0001, 7'h0a, 7'h14, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'h0030, 7'h0a, 7'h14, 1'b0, 1'b1, 16'h0031, 7'h0a, 7'h14, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h6be3},
    '{16'hffff, 7'h7f, 7'h00, 1'b1, 1'b0, 16'hf839, 7'h7f, 7'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'h0000}
  };

  ccs_regs #(
    .DEEMPH_48K   (D48),
    .DEEMPH_44K1  (D44),
    .AGC_TC_48K   (A48),
    .AGC_TC_44K1  (A44),
    .TSC_DIV_48K  (T48),
    .TSC_DIV_44K1 (T44),
    .REVISION     (REV)
  ) dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_ovf_event(i_ovf_event), .i_dac_left_vol(i_dac_left_vol),
    .i_dac_right_vol(i_dac_right_vol), .i_agc_selected(i_agc_selected),
    .i_effects_filter_enable(i_effects_filter_enable), .o_dac_left_vol_eff(o_dac_left_vol_eff),
    .o_dac_right_vol_eff(o_dac_right_vol_eff), .o_deemph_coef(o_deemph_coef),
    .o_agc_time_const(o_agc_time_const), .o_tsc_clk_div(o_tsc_clk_div),
    .o_transfer_mode_select(o_transfer_mode_select), .o_master_slave_select(o_master_slave_select),
    .o_mic_agc_clip_step_active(o_mic_agc_clip_step_active), .o_effects_active(o_effects_active),
    .o_left_bass_coef_n0(o_left_bass_coef_n0)
  );

  // 200 mhz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // compare and count; case inequality so unknowns never match
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // tasks start and end at a falling edge
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp, input string what);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    chk("read valid", {15'h0000, o_reg_rvalid}, 16'h0001);
    chk(what, o_reg_rdata, exp);
    // strobe stays low one edge, so a following read never re-raises it in the same step
    @(negedge i_clk);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    failures++;
    $display("Error watchdog expired");
    test_done();
  end

  initial begin
    {i_sys_rst, i_reg_wr, i_reg_rd, i_agc_selected, i_effects_filter_enable} = 5'h10;
    {i_reg_addr, i_reg_wdata, i_ovf_event, i_dac_left_vol, i_dac_right_vol} = '0;
    repeat (10) @(negedge i_clk);
    i_sys_rst = 1'b0;
    chk("deemph at reset", o_deemph_coef, D48);
    rd_chk(MODE_STATUS_ADDR, {13'h0000, REV}, "mode reset");
    rd_chk(COEF_N0_ADDR, 16'h6be3, "coef reset");
    // table of control settings
    foreach (rows[n]) begin
      i_dac_left_vol = rows[n].lv;
      i_dac_right_vol = rows[n].rv;
      i_agc_selected = rows[n].agc;
      i_effects_filter_enable = rows[n].fe;
      wr_reg(MODE_STATUS_ADDR, rows[n].wd); // rows keep the 48 kHz setting unless testing 44.1 kHz
      rd_chk(MODE_STATUS_ADDR, rows[n].rd, "mode readback");
      chk("left vol", {9'h000, o_dac_left_vol_eff}, {9'h000, rows[n].el});
      chk("right vol", {9'h000, o_dac_right_vol_eff}, {9'h000, rows[n].er});
      chk("deemph", o_deemph_coef, rows[n].rate ? D44 : D48);
      chk("agc tc", {8'h00, o_agc_time_const}, {8'h00, rows[n].rate ? A44 : A48});
      chk("tsc div", {8'h00, o_tsc_clk_div}, {8'h00, rows[n].rate ? T44 : T48});
      chk("xfer", {15'h0000, o_transfer_mode_select}, {15'h0000, rows[n].xfer});
      chk("role", {15'h0000, o_master_slave_select}, {15'h0000, rows[n].ms});
      chk("clip", {15'h0000, o_mic_agc_clip_step_active}, {15'h0000, rows[n].clip});
      chk("effects", {15'h0000, o_effects_active}, {15'h0000, rows[n].fx});
      chk("coef out", o_left_bass_coef_n0, rows[n].coef);
    end
    // each overflow flag alone: set, read, cleared by the read
    i_effects_filter_enable = 1'b1;
    wr_reg(MODE_STATUS_ADDR, 16'h0000);
    for (int k = 0; k < NUM_OVF; k++) begin
      i_ovf_event = 3'(3'h1 << k);
      @(negedge i_clk);
      i_ovf_event = 3'h0;
      rd_chk(MODE_STATUS_ADDR, 16'h0001 | 16'(16'h0040 << k), "flag set");
      rd_chk(MODE_STATUS_ADDR, 16'h0001, "flag cleared");
    end
    // event during the clearing read keeps the flags
    i_ovf_event = 3'h7;
    @(negedge i_clk);
    rd_chk(MODE_STATUS_ADDR, 16'h01c1, "flags with event");
    i_ovf_event = 3'h0;
    rd_chk(COEF_N0_ADDR, 16'h6be3, "coef read");
    rd_chk(MODE_STATUS_ADDR, 16'h01c1, "flags survive other reads");
    rd_chk(MODE_STATUS_ADDR, 16'h0001, "flags cleared");
    // unmapped place: write ignored, read gives zero
    wr_reg(6'h05, 16'hffff);
    rd_chk(6'h05, 16'h0000, "unmapped read");
    rd_chk(MODE_STATUS_ADDR, 16'h0001, "mode after unmapped write");
    // coefficient write, then simultaneous read and write sees old word
    wr_reg(COEF_N0_ADDR, 16'h8001);
    rd_chk(COEF_N0_ADDR, 16'h8001, "coef readback");
    chk("coef out enabled", o_left_bass_coef_n0, 16'h8001);
    i_reg_wr = 1'b1;
    i_reg_wdata = 16'h7ffe;
    rd_chk(COEF_N0_ADDR, 16'h8001, "coef during write");
    i_reg_wr = 1'b0;
    rd_chk(COEF_N0_ADDR, 16'h7ffe, "coef after write");
    i_effects_filter_enable = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("coef out disabled", o_left_bass_coef_n0, 16'h0000);
    // reset in mid-run with fields and a flag set
    i_ovf_event = 3'h4;
    wr_reg(MODE_STATUS_ADDR, 16'hf838);
    i_ovf_event = 3'h0;
    i_sys_rst = 1'b1;
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    rd_chk(MODE_STATUS_ADDR, {13'h0000, REV}, "mode after reset");
    rd_chk(COEF_N0_ADDR, 16'h6be3, "coef after reset");
    @(negedge i_clk);
    chk("read valid idle", {15'h0000, o_reg_rvalid}, 16'h0000);
    test_done();
  end

endmodule
